// file: shared/rsto_pkg.sv
// Shared constants and carrier types for the receive system TDM output stage
package rsto_pkg;
   // Clock rates
   localparam int SYS_CLK_HZ = 125_000_000;
   localparam longint T1_RATE_HZ = 64'd1_544_000;
   localparam longint E1_RATE_HZ = 64'd2_048_000;
   // Phase accumulator width for the master clock generator
   localparam int NCO_BITS = 32;
   // Slot layout
   localparam int SLOT_BITS = 8;
   localparam int PAIR_BITS = 16;
   localparam logic [3:0] SIG_PAD = 4'h0;
   // Values after reset, and the bus count after a pair load
   localparam logic [2:0] BIT_CNT_RST = 3'h0;
   localparam logic [3:0] MUX_CNT_RST = 4'h0;
   localparam logic [3:0] MUX_CNT_AFTER_LOAD = 4'h1;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [15:0] PAIR_RST = 16'h0000;

   // One channel slot as the framer hands it over
   typedef struct packed {
      logic [7:0] data;
      logic [3:0] sig;
   } rsto_slot_t;

   // Both links' slots for one interleaved pair
   typedef struct packed {
      rsto_slot_t link1;
      rsto_slot_t link2;
   } rsto_pair_t;
endpackage

// file: hdl/rsto_ser.sv
// Per-link serializer for one channel slot of data and signaling
`timescale 1ns/100ps
module rsto_ser (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Bit timing
   input wire logic strobe,
   // Slot source
   input wire rsto_pkg::rsto_slot_t slot,
   output logic take,
   // Serial outputs
   output logic data_out,
   output logic sig_out
);
   import rsto_pkg::*;

   logic [2:0] cnt_q, cnt_d;
   logic [7:0] dsh_q, dsh_d;
   logic [7:0] ssh_q, ssh_d;
   logic data_q, data_d;
   logic sig_q, sig_d;
   logic take_d;
   logic [7:0] sig_byte;

   always_comb begin
      // Signaling nibble rides in b5..b8; b1 goes out first
      sig_byte = {SIG_PAD, slot.sig};
      cnt_d = cnt_q;
      dsh_d = dsh_q;
      ssh_d = ssh_q;
      data_d = data_q;
      sig_d = sig_q;
      take_d = 1'b0;
      if (strobe) begin
         cnt_d = 3'(cnt_q + 3'h1);
         if (cnt_q == BIT_CNT_RST) begin
            data_d = slot.data[7];
            sig_d = sig_byte[7];
            dsh_d = {slot.data[6:0], 1'b0};
            ssh_d = {sig_byte[6:0], 1'b0};
            take_d = 1'b1;
         end else begin
            data_d = dsh_q[7];
            sig_d = ssh_q[7];
            dsh_d = {dsh_q[6:0], 1'b0};
            ssh_d = {ssh_q[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= BIT_CNT_RST;
         dsh_q <= BYTE_RST;
         ssh_q <= BYTE_RST;
         data_q <= 1'b0;
         sig_q <= 1'b0;
         take <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         dsh_q <= dsh_d;
         ssh_q <= ssh_d;
         data_q <= data_d;
         sig_q <= sig_d;
         take <= take_d;
      end
   end

   assign data_out = data_q;
   assign sig_out = sig_q;
endmodule

// file: hdl/rsto_top.sv
// Receive system TDM output stage: per-link and multiplexed serial outputs
`timescale 1ns/100ps
module rsto_top #(
   parameter int NCO_W = rsto_pkg::NCO_BITS
) (
   // System clock and reset
   input wire logic SYS_CLK,
   input wire logic RESETN,
   // Multiplexed bus clock and frame pulse
   input wire logic MUX_RX_SYS_CLOCK,
   input wire logic MUX_RX_FRAME_PULSE,
   // Mode selection
   input wire logic MODE_MUX,
   input wire logic [1:0] MODE_SLAVE,
   input wire logic [1:0] LINK_E1,
   input wire logic [1:0] RX_SLAVE_SHARED_CLOCK_SEL,
   // Channel slots from the framer
   input wire rsto_pkg::rsto_slot_t CH_SLOT_1,
   input wire rsto_pkg::rsto_slot_t CH_SLOT_2,
   output logic [1:0] CH_TAKE,
   // Per-link receive clock pins
   input wire logic [1:0] RX_SYS_CLOCK_I,
   output logic [1:0] RX_SYS_CLOCK_O,
   output logic [1:0] RX_SYS_CLOCK_OE,
   // Per-link serial outputs
   output logic [1:0] RX_SYS_DATA_OUT,
   output logic [1:0] RX_SYS_SIGNALING_OUT,
   // Multiplexed serial outputs
   output logic MUX_RX_SYS_DATA_OUT,
   output logic MUX_RX_SYS_SIGNALING_OUT
);
   import rsto_pkg::*;

   if (NCO_W < 24 || NCO_W > 40) begin : g_bad_nco
      $error("NCO_W must lie between 24 and 40");
   end

   // Phase step for a given output rate
   function automatic logic [NCO_W-1:0] nco_step(input longint rate_hz);
      longint full;
      full = (rate_hz << NCO_W) / longint'(SYS_CLK_HZ);
      return full[NCO_W-1:0];
   endfunction

   localparam logic [NCO_W-1:0] STEP_T1 = nco_step(T1_RATE_HZ);
   localparam logic [NCO_W-1:0] STEP_E1 = nco_step(E1_RATE_HZ);

   // System clock domain
   logic [NCO_W-1:0] acc_q [2];
   logic [NCO_W-1:0] acc_d [2];
   logic [1:0] gen_prev_q, gen_prev_d;
   logic [1:0] pin_s1_q, pin_s1_d;
   logic [1:0] pin_s2_q, pin_s2_d;
   logic [1:0] pin_s3_q, pin_s3_d;
   logic [1:0] oe_q, oe_d;
   logic [1:0] take_q, take_d;
   logic req_s1_q, req_s1_d;
   logic req_s2_q, req_s2_d;
   logic req_s3_q, req_s3_d;
   rsto_pair_t hold_q, hold_d;
   logic [1:0] gen_fall;
   logic [1:0] pin_fall;
   logic [1:0] strobe;
   logic [1:0] ser_take;
   logic mux_pair;
   logic req_q;

   always_comb begin
      pin_s1_d = RX_SYS_CLOCK_I;
      pin_s2_d = pin_s1_q;
      pin_s3_d = pin_s2_q;
      for (int i = 0; i < 2; i++) begin
         // The generator idles whenever the pin is not ours to drive
         if (MODE_SLAVE[i] || MODE_MUX) begin
            acc_d[i] = '0;
         end else begin
            acc_d[i] = acc_q[i] + (LINK_E1[i] ? STEP_E1 : STEP_T1);
         end
         gen_prev_d[i] = acc_q[i][NCO_W-1];
         gen_fall[i] = gen_prev_q[i] & ~acc_q[i][NCO_W-1];
         pin_fall[i] = pin_s3_q[i] & ~pin_s2_q[i];
         oe_d[i] = ~MODE_SLAVE[i] & ~MODE_MUX;
      end
      for (int i = 0; i < 2; i++) begin
         if (MODE_MUX) begin
            strobe[i] = 1'b0;
         end else if (MODE_SLAVE[i]) begin
            // Shared select hands link 1's clock to this link
            strobe[i] = RX_SLAVE_SHARED_CLOCK_SEL[i] ? pin_fall[0] : pin_fall[i];
         end else begin
            strobe[i] = gen_fall[i];
         end
      end
      req_s1_d = req_q;
      req_s2_d = req_s1_q;
      req_s3_d = req_s2_q;
      mux_pair = (req_s3_q ^ req_s2_q) & MODE_MUX;
      hold_d = hold_q;
      if (mux_pair) begin
         hold_d.link1 = CH_SLOT_1;
         hold_d.link2 = CH_SLOT_2;
      end
      take_d = ser_take | {2{mux_pair}};
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         for (int i = 0; i < 2; i++) begin
            acc_q[i] <= '0;
         end
         gen_prev_q <= 2'h0;
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
         pin_s3_q <= 2'h0;
         oe_q <= 2'h0;
         take_q <= 2'h0;
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_s3_q <= 1'b0;
         hold_q <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            acc_q[i] <= acc_d[i];
         end
         gen_prev_q <= gen_prev_d;
         pin_s1_q <= pin_s1_d;
         pin_s2_q <= pin_s2_d;
         pin_s3_q <= pin_s3_d;
         oe_q <= oe_d;
         take_q <= take_d;
         req_s1_q <= req_s1_d;
         req_s2_q <= req_s2_d;
         req_s3_q <= req_s3_d;
         hold_q <= hold_d;
      end
   end

   rsto_ser u_ser1 (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .strobe(strobe[0]),
      .slot(CH_SLOT_1),
      .take(ser_take[0]),
      .data_out(RX_SYS_DATA_OUT[0]),
      .sig_out(RX_SYS_SIGNALING_OUT[0])
   );

   rsto_ser u_ser2 (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .strobe(strobe[1]),
      .slot(CH_SLOT_2),
      .take(ser_take[1]),
      .data_out(RX_SYS_DATA_OUT[1]),
      .sig_out(RX_SYS_SIGNALING_OUT[1])
   );

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         RX_SYS_CLOCK_O[i] = acc_q[i][NCO_W-1];
      end
   end
   assign RX_SYS_CLOCK_OE = oe_q;
   assign CH_TAKE = take_q;

   // Multiplexed clock domain
   // Hold registers cross as a word: the pair is captured a few system
   // cycles after a request toggle and not read here until the next pair
   // boundary, sixteen multiplexed clocks later unless a frame pulse restarts the pair sooner.
   logic mrst_s1_q, mrst_s2_q;
   logic mux_rst_n;
   logic [3:0] mcnt_q, mcnt_d;
   logic [15:0] mdsh_q, mdsh_d;
   logic [15:0] mssh_q, mssh_d;
   logic mdata_q, mdata_d;
   logic msig_q, msig_d;
   logic req_d;
   logic [15:0] data_pair;
   logic [15:0] sig_pair;

   always_ff @(posedge MUX_RX_SYS_CLOCK) begin
      mrst_s1_q <= RESETN;
      mrst_s2_q <= mrst_s1_q;
   end
   assign mux_rst_n = mrst_s2_q;

   always_comb begin
      data_pair = {hold_q.link1.data, hold_q.link2.data};
      sig_pair = {SIG_PAD, hold_q.link1.sig, SIG_PAD, hold_q.link2.sig};
      mcnt_d = 4'(mcnt_q + 4'h1);
      mdsh_d = {mdsh_q[14:0], 1'b0};
      mssh_d = {mssh_q[14:0], 1'b0};
      mdata_d = mdsh_q[15];
      msig_d = mssh_q[15];
      req_d = req_q;
      // Frame pulse restarts the pair with link 1 on its first bit
      if (MUX_RX_FRAME_PULSE || mcnt_q == MUX_CNT_RST) begin
         mcnt_d = MUX_CNT_AFTER_LOAD;
         mdata_d = data_pair[15];
         msig_d = sig_pair[15];
         mdsh_d = {data_pair[14:0], 1'b0};
         mssh_d = {sig_pair[14:0], 1'b0};
         req_d = ~req_q;
      end
   end

   always_ff @(posedge MUX_RX_SYS_CLOCK) begin
      if (!mux_rst_n) begin
         mcnt_q <= MUX_CNT_RST;
         mdsh_q <= PAIR_RST;
         mssh_q <= PAIR_RST;
         mdata_q <= 1'b0;
         msig_q <= 1'b0;
         req_q <= 1'b0;
      end else begin
         mcnt_q <= mcnt_d;
         mdsh_q <= mdsh_d;
         mssh_q <= mssh_d;
         mdata_q <= mdata_d;
         msig_q <= msig_d;
         req_q <= req_d;
      end
   end

   assign MUX_RX_SYS_DATA_OUT = mdata_q;
   assign MUX_RX_SYS_SIGNALING_OUT = msig_q;
endmodule

// file: tb/rsto_monitor.sv
// Port checker for the receive system TDM output stage
`timescale 1ns/100ps
module rsto_monitor (
   // Clocks and reset
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic MUX_RX_SYS_CLOCK,
   // Modes and pins
   input wire logic MODE_MUX,
   input wire logic [1:0] MODE_SLAVE,
   input wire logic [1:0] RX_SLAVE_SHARED_CLOCK_SEL,
   input wire logic [1:0] CH_TAKE,
   input wire logic [1:0] RX_SYS_CLOCK_I,
   input wire logic [1:0] RX_SYS_CLOCK_O,
   input wire logic [1:0] RX_SYS_CLOCK_OE,
   input wire logic [1:0] RX_SYS_DATA_OUT,
   input wire logic [1:0] RX_SYS_SIGNALING_OUT,
   input wire logic MUX_RX_SYS_DATA_OUT,
   input wire logic MUX_RX_SYS_SIGNALING_OUT
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RESETN);
   // Link 2 may be timed by the link 1 pin
   wire logic src2 = RX_SLAVE_SHARED_CLOCK_SEL[1] ? RX_SYS_CLOCK_I[0] : RX_SYS_CLOCK_I[1];
   wire logic mst0 = !MODE_MUX && !MODE_SLAVE[0];
   wire logic slv1 = !MODE_MUX && MODE_SLAVE[1];
   // Outputs move just after a falling link clock, which was high before
   property p_d_mst;
      $changed(RX_SYS_DATA_OUT[0]) && mst0 |-> !RX_SYS_CLOCK_O[0] && $past(RX_SYS_CLOCK_O[0], 3);
   endproperty
   a_d_mst: assert property (p_d_mst) else $error("data edge");
   property p_s_mst;
      $changed(RX_SYS_SIGNALING_OUT[0]) && mst0 |-> !RX_SYS_CLOCK_O[0] && $past(RX_SYS_CLOCK_O[0], 3);
   endproperty
   a_s_mst: assert property (p_s_mst) else $error("signaling edge");
   // Slave pins pass a synchroniser, so the change trails the fall by a few cycles;
   // a pin edge landing on a clock edge may be seen one cycle late
   property p_d_slv;
      $changed(RX_SYS_DATA_OUT[1]) && slv1 |-> !$past(src2, 2) && $past(src2, 8);
   endproperty
   a_d_slv: assert property (p_d_slv) else $error("slave data edge");
   property p_s_slv;
      $changed(RX_SYS_SIGNALING_OUT[1]) && slv1 |-> !$past(src2, 2) && $past(src2, 8);
   endproperty
   a_s_slv: assert property (p_s_slv) else $error("slave signaling edge");
   // The register still holds its reset value at the edge that releases reset
   property p_oe;
      RESETN && $stable(MODE_SLAVE) && $stable(MODE_MUX) |=>
         RX_SYS_CLOCK_OE == (~$past(MODE_SLAVE) & ~{2{$past(MODE_MUX)}});
   endproperty
   a_oe: assert property (p_oe) else $error("clock drive");
   property p_md;
      $changed(MUX_RX_SYS_DATA_OUT) |-> $rose(MUX_RX_SYS_CLOCK);
   endproperty
   a_md: assert property (p_md) else $error("bus data edge");
   property p_ms;
      $changed(MUX_RX_SYS_SIGNALING_OUT) |-> $rose(MUX_RX_SYS_CLOCK);
   endproperty
   a_ms: assert property (p_ms) else $error("bus signaling edge");
   property p_both;
      MODE_MUX && CH_TAKE != 2'b00 |-> CH_TAKE == 2'b11;
   endproperty
   a_both: assert property (p_both) else $error("bus take");
   c_mst: cover property (CH_TAKE[0] && mst0);
   c_shr: cover property (CH_TAKE[1] && slv1 && RX_SLAVE_SHARED_CLOCK_SEL[1]);
   c_mux: cover property (MODE_MUX && CH_TAKE == 2'b11);
endmodule

bind rsto_top rsto_monitor i_mon (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
   .MUX_RX_SYS_CLOCK(MUX_RX_SYS_CLOCK), .MODE_MUX(MODE_MUX), .MODE_SLAVE(MODE_SLAVE),
   .RX_SLAVE_SHARED_CLOCK_SEL(RX_SLAVE_SHARED_CLOCK_SEL), .CH_TAKE(CH_TAKE),
   .RX_SYS_CLOCK_I(RX_SYS_CLOCK_I), .RX_SYS_CLOCK_O(RX_SYS_CLOCK_O),
   .RX_SYS_CLOCK_OE(RX_SYS_CLOCK_OE), .RX_SYS_DATA_OUT(RX_SYS_DATA_OUT),
   .RX_SYS_SIGNALING_OUT(RX_SYS_SIGNALING_OUT), .MUX_RX_SYS_DATA_OUT(MUX_RX_SYS_DATA_OUT),
   .MUX_RX_SYS_SIGNALING_OUT(MUX_RX_SYS_SIGNALING_OUT));

// file: tb/rsto_sysmodel.sv
// Backplane model: slave link clocks and the bus frame pulse
`timescale 1ns/100ps
module rsto_sysmodel (
   // Controls and bus clock
   input wire logic [1:0] run,
   input wire logic mux_clk,
   // Towards the device
   output logic [1:0] pin,
   output logic fp
);
   int fcnt;
   logic pin0, pin1;
   // Stopped pins rest high on their pull-ups
   initial begin
      pin0 = 1'b1;
      forever #244.1 pin0 = run[0] ? ~pin0 : 1'b1;
   end
   initial begin
      pin1 = 1'b1;
      #50.3;
      forever #122.1 pin1 = run[1] ? ~pin1 : 1'b1;
   end
   assign pin = {pin1, pin0};
   // Frame start every four pairs keeps the bus aligned to pair boundaries
   initial begin
      fp = 1'b0;
      forever begin
         @(posedge mux_clk);
         fcnt <= (fcnt == 63) ? 0 : fcnt + 1;
         fp <= (fcnt == 0);
      end
   end
endmodule

// file: tb/rsto_top_test.sv
// Self-checking bench for the receive system TDM output stage
`timescale 1ns/100ps
module rsto_top_test;
   import rsto_pkg::*;
   logic clk, rst_n, mclk, mode_mux, fp, mdout, msout;
   logic [1:0] slave, e1, sel, run, take, cko, coe, dout, sout, mpin;
   rsto_slot_t s1, s2;
   int err_count, compares, cyc;
   // Pin level: the device while it drives, else the backplane
   wire logic [1:0] pin = (coe & cko) | (~coe & mpin);
   wire logic [1:0] bclk = {slave[1] ? (sel[1] ? pin[0] : pin[1]) : cko[1],
      slave[0] ? pin[0] : cko[0]};
   rsto_top i_dut (.SYS_CLK(clk), .RESETN(rst_n), .MUX_RX_SYS_CLOCK(mclk),
      .MUX_RX_FRAME_PULSE(fp), .MODE_MUX(mode_mux), .MODE_SLAVE(slave), .LINK_E1(e1),
      .RX_SLAVE_SHARED_CLOCK_SEL(sel), .CH_SLOT_1(s1), .CH_SLOT_2(s2), .CH_TAKE(take),
      .RX_SYS_CLOCK_I(pin), .RX_SYS_CLOCK_O(cko), .RX_SYS_CLOCK_OE(coe),
      .RX_SYS_DATA_OUT(dout), .RX_SYS_SIGNALING_OUT(sout), .MUX_RX_SYS_DATA_OUT(mdout),
      .MUX_RX_SYS_SIGNALING_OUT(msout));
   rsto_sysmodel i_sys (.run(run), .mux_clk(mclk), .pin(mpin), .fp(fp));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      mclk = 1'b0;
      #3;
      // Fast bus clock keeps the run short; the bus logic does not depend on its rate
      forever #80 mclk = ~mclk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Long enough for the bus clock domain to see its reset too
   task automatic restart(input logic m, input logic [1:0] sl, input logic [1:0] se);
      @(posedge clk);
      rst_n <= 1'b0;
      mode_mux <= m;
      slave <= sl;
      sel <= se;
      run <= sl & ~se;
      repeat (100) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task automatic t_link(input int l, input int span);
      rsto_slot_t x;
      logic [7:0] d, s;
      int t0;
      for (int n = 0; n < 3; n++) begin
         @(posedge clk iff take[l] === 1'b1);
         if (n > 0 && span > 0 && (cyc - t0 < span - 2 || cyc - t0 > span + 2)) begin
            err_count++;
            $display("[FAIL] %0t slot spacing %0d", $time, cyc - t0);
         end
         t0 = cyc;
         x = l ? s2 : s1;
         if (l == 0) s1 <= '{data: x.data + 8'h3B, sig: x.sig + 4'h5};
         else s2 <= '{data: x.data + 8'h3B, sig: x.sig + 4'h5};
         for (int b = 0; b < 8; b++) begin
            @(posedge bclk[l]);
            d = {d[6:0], dout[l]};
            s = {s[6:0], sout[l]};
         end
         chk({8'h00, d}, {8'h00, x.data});
         chk({8'h00, s}, {12'h000, x.sig});
      end
   endtask
   task automatic t_mux(input rsto_slot_t a, input rsto_slot_t b);
      logic [15:0] d, s;
      @(posedge clk);
      s1 <= a;
      s2 <= b;
      repeat (3) @(posedge mclk iff fp === 1'b1);
      for (int i = 0; i < 16; i++) begin
         @(negedge mclk);
         d = {d[14:0], mdout};
         s = {s[14:0], msout};
      end
      chk(d, {a.data, b.data});
      chk(s, {4'h0, a.sig, 4'h0, b.sig});
   endtask
   initial begin
      #400000;
      err_count++;
      end_of_test;
   end
   initial begin
      rst_n = 1'b0;
      mode_mux = 1'b0;
      slave = 2'b00;
      sel = 2'b00;
      run = 2'b00;
      e1 = 2'b10;
      s1 = '{data: 8'hA5, sig: 4'h9};
      s2 = '{data: 8'h3C, sig: 4'h6};
      err_count = 0;
      compares = 0;
      restart(1'b0, 2'b00, 2'b00);
      t_link(0, 648);
      t_link(1, 488);
      restart(1'b0, 2'b11, 2'b00);
      t_link(0, 0);
      t_link(1, 0);
      restart(1'b0, 2'b11, 2'b10);
      t_link(1, 0);
      restart(1'b1, 2'b00, 2'b00);
      t_mux('{data: 8'h81, sig: 4'hC}, '{data: 8'h5E, sig: 4'h3});
      t_mux('{data: 8'h17, sig: 4'h1}, '{data: 8'hE8, sig: 4'h8});
      end_of_test;
   end
endmodule
